/* common/flsa_pkg.sv */
/*
 * Constants and state types for the fault record serial access block.
 * Assumes a 125 MHz system clock and a two-wire serial target port whose
 * pins are already synchronous to that clock.
 */
package flsa_pkg;

    // ========================================================================
    // Storage geometry
    // ========================================================================
    localparam int RECORD_COUNT = 16;
    localparam int RECORD_BYTES = 7;

    // ========================================================================
    // Command codes and keys
    // ========================================================================
    localparam logic [7:0] CMD_PROG_ENTER  = 8'h04;
    localparam logic [7:0] CMD_PROG_LEAVE  = 8'h05;
    localparam logic [7:0] CMD_ERASE       = 8'h71;
    localparam logic [7:0] CMD_READ_HOLD   = 8'h73;
    localparam logic [7:0] CMD_UNLOCK      = 8'h74;
    localparam logic [7:0] CMD_READ_RECORD = 8'h75;
    localparam logic [7:0] CMD_READ_ALL    = 8'h76;
    localparam logic [7:0] KEY_PROG_HI     = 8'hE5;
    localparam logic [7:0] KEY_PROG_LO     = 8'h3D;
    localparam logic [7:0] KEY_UNLOCK      = 8'hAC;

    // ========================================================================
    // Access status register values and fields, record select field, fill bytes
    // ========================================================================
    localparam logic [7:0] STATUS_SAFE      = 8'h00;
    localparam logic [7:0] STATUS_RECORDING = 8'h30;
    localparam logic [7:0] STATUS_PENDING   = 8'hC0;
    localparam logic [7:0] STATUS_READABLE  = 8'hF0;
    localparam int         STATUS_REQ_MSB   = 7;
    localparam int         STATUS_GNT_MSB   = 5;
    localparam int         SELECT_MSB       = 7;
    localparam int         SELECT_LSB       = 4;
    localparam logic [7:0] IDLE_READ_BYTE   = 8'hFF;
    localparam logic [7:0] ERASED_BYTE      = 8'hFF;

    // ========================================================================
    // Bus and timing
    // ========================================================================
    // Target address value is arbitrary.
    localparam logic [6:0] TARGET_ADDRESS   = 7'h5A;
    localparam int         CLOCK_MHZ        = 125;
    localparam int         PROGRAM_TIME_US  = 20;
    localparam int         ERASE_TIME_US    = 30;
    localparam int         PROGRAM_CYCLES   = PROGRAM_TIME_US * CLOCK_MHZ;
    localparam int         ERASE_CYCLES     = ERASE_TIME_US * CLOCK_MHZ;
    localparam int         BUSY_WIDTH       = 13;

    // ========================================================================
    // State types
    // ========================================================================
    typedef enum logic [2:0] {
        BUS_IDLE,
        BUS_ADDRESS,
        BUS_WRITE,
        BUS_ACK,
        BUS_READ,
        BUS_READ_ACK,
        BUS_SKIP
    } flsa_bus_e;

    typedef enum logic [1:0] {
        LOCK_RECORDING,
        LOCK_PENDING,
        LOCK_READABLE
    } flsa_lock_e;

endpackage

/* verilog/flsa_fault_log_access.sv */
/*
 * Serial target for the fault record store: unlock with key, access status,
 * erase, holding register read, single record and streaming record reads.
 * Assumes scl and sda samples are synchronous to i_clock and that the bus
 * controller holds each level for several clock cycles.
 */
`timescale 1ns/1ps

module flsa_fault_log_access
(
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_sda_out,
    output logic             o_sda_oe,
    input  wire logic        i_fault_log_mode,
    input  wire logic        i_fault_event,
    input  wire logic [55:0] i_fault_record,
    input  wire logic        i_reconfig_req,
    output logic             o_reconfig_accept,
    output logic             o_reconfig_reject,
    output logic [3:0]       o_next_record,
    output logic             o_log_full,
    output logic [7:0]       o_access_status,
    output logic             o_program_mode
);

    // ========================================================================
    // State
    // ========================================================================
    typedef struct packed {
        logic [15:0][6:0][7:0]          mem;
        logic [6:0][7:0]                hold;
        flsa_pkg::flsa_bus_e            bus;
        flsa_pkg::flsa_lock_e           lock;
        logic                           scl_prev;
        logic                           sda_prev;
        logic [3:0]                     bit_count;
        logic [7:0]                     shift;
        logic                           read_dir;
        logic                           nack;
        logic [1:0]                     write_index;
        logic [7:0]                     command;
        logic                           key_hi_ok;
        logic [3:0]                     rec_sel;
        logic [2:0]                     byte_sel;
        logic [3:0]                     next_record;
        logic                           full;
        logic                           program_mode;
        logic                           erasing;
        logic                           writing;
        logic [flsa_pkg::BUSY_WIDTH-1:0] busy_count;
        logic [7:0]                     status;
        logic                           sda_out;
        logic                           sda_oe;
        logic                           reconfig_accept;
        logic                           reconfig_reject;
    } flsa_state_s;

    flsa_state_s st;
    flsa_state_s next_st;

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb
    begin
        logic       scl_rise;
        logic       scl_fall;
        logic       start_seen;
        logic       stop_seen;
        logic       granted;
        logic [7:0] rx;
        logic [7:0] tx;

        next_st    = st;
        scl_rise   = i_scl && !st.scl_prev;
        scl_fall   = !i_scl && st.scl_prev;
        start_seen = i_scl && st.scl_prev && st.sda_prev && !i_sda;
        stop_seen  = i_scl && st.scl_prev && !st.sda_prev && i_sda;
        granted    = i_fault_log_mode && st.lock == flsa_pkg::LOCK_READABLE;
        rx         = st.shift;
        tx         = flsa_pkg::IDLE_READ_BYTE;

        next_st.scl_prev        = i_scl;
        next_st.sda_prev        = i_sda;
        next_st.reconfig_accept = 1'b0;
        next_st.reconfig_reject = 1'b0;

        // Byte served by a read: status after unlock, else gated data.
        if (st.command == flsa_pkg::CMD_UNLOCK)
            tx = st.status;
        else if (granted && st.command == flsa_pkg::CMD_READ_HOLD)
            tx = st.hold[st.byte_sel];
        else if (granted && (st.command == flsa_pkg::CMD_READ_RECORD ||
                             st.command == flsa_pkg::CMD_READ_ALL))
            tx = st.mem[st.rec_sel][st.byte_sel];

        // ====================================================================
        // Array timing and recording
        // ====================================================================
        if (st.busy_count != '0)
            next_st.busy_count = st.busy_count - 1'b1;
        else
        begin
            next_st.erasing = 1'b0;
            next_st.writing = 1'b0;
        end
        if (st.lock == flsa_pkg::LOCK_PENDING && st.busy_count == '0)
            next_st.lock = flsa_pkg::LOCK_READABLE;
        // A fault arriving while the array is busy is kept only in the
        // holding register; the array write would collide with the program or erase in progress.
        if (i_fault_event && i_fault_log_mode && st.lock == flsa_pkg::LOCK_RECORDING)
        begin
            next_st.hold = i_fault_record;
            if (!st.full && st.busy_count == '0)
            begin
                next_st.mem[st.next_record] = i_fault_record;
                next_st.next_record = st.next_record + 1'b1;
                next_st.full        = st.next_record == 4'hF;
                next_st.writing     = 1'b1;
                next_st.busy_count  = flsa_pkg::BUSY_WIDTH'(flsa_pkg::PROGRAM_CYCLES);
            end
        end
        if (i_reconfig_req)
        begin
            next_st.reconfig_reject = st.writing;
            next_st.reconfig_accept = !st.writing;
        end

        // ====================================================================
        // Serial target
        // ====================================================================
        if (start_seen)
        begin
            next_st.bus         = flsa_pkg::BUS_ADDRESS;
            next_st.bit_count   = 4'h0;
            next_st.write_index = 2'h0;
            next_st.sda_oe      = 1'b0;
        end
        else if (stop_seen)
        begin
            next_st.bus    = flsa_pkg::BUS_IDLE;
            next_st.sda_oe = 1'b0;
        end
        else
        begin
            case (st.bus)
                flsa_pkg::BUS_ADDRESS,
                flsa_pkg::BUS_WRITE:
                begin
                    if (scl_rise)
                    begin
                        next_st.shift     = {st.shift[6:0], i_sda};
                        next_st.bit_count = st.bit_count + 1'b1;
                    end
                    else if (scl_fall && st.bit_count == 4'h8)
                    begin
                        next_st.bus    = flsa_pkg::BUS_ACK;
                        next_st.sda_oe = 1'b1;
                        if (st.bus == flsa_pkg::BUS_ADDRESS)
                        begin
                            next_st.read_dir = rx[0];
                            if (rx[7:1] != flsa_pkg::TARGET_ADDRESS)
                            begin
                                next_st.bus    = flsa_pkg::BUS_SKIP;
                                next_st.sda_oe = 1'b0;
                            end
                        end
                        else
                        begin
                            if (st.write_index != 2'h3)
                                next_st.write_index = st.write_index + 1'b1;
                            if (st.write_index == 2'h0)
                            begin
                                next_st.command  = rx;
                                next_st.byte_sel = 3'h0;
                                if (rx == flsa_pkg::CMD_PROG_LEAVE)
                                    next_st.program_mode = 1'b0;
                                if (rx == flsa_pkg::CMD_READ_ALL)
                                    next_st.rec_sel = 4'h0;
                                if (rx == flsa_pkg::CMD_ERASE && granted &&
                                    st.program_mode && st.busy_count == '0)
                                begin
                                    next_st.mem         = '1;
                                    next_st.next_record = 4'h0;
                                    next_st.full        = 1'b0;
                                    next_st.erasing     = 1'b1;
                                    next_st.busy_count  =
                                        flsa_pkg::BUSY_WIDTH'(flsa_pkg::ERASE_CYCLES);
                                end
                            end
                            else if (st.write_index == 2'h1)
                            begin
                                next_st.key_hi_ok = rx == flsa_pkg::KEY_PROG_HI;
                                if (st.command == flsa_pkg::CMD_READ_RECORD)
                                    next_st.rec_sel =
                                        rx[flsa_pkg::SELECT_MSB:flsa_pkg::SELECT_LSB];
                                if (st.command == flsa_pkg::CMD_UNLOCK && i_fault_log_mode)
                                begin
                                    if (rx != flsa_pkg::KEY_UNLOCK)
                                        next_st.lock = flsa_pkg::LOCK_RECORDING;
                                    else if (st.lock == flsa_pkg::LOCK_RECORDING)
                                        next_st.lock = flsa_pkg::LOCK_PENDING;
                                end
                            end
                            else if (st.write_index == 2'h2 &&
                                     st.command == flsa_pkg::CMD_PROG_ENTER &&
                                     st.key_hi_ok && rx == flsa_pkg::KEY_PROG_LO)
                                next_st.program_mode = 1'b1;
                        end
                    end
                end
                flsa_pkg::BUS_ACK:
                begin
                    if (scl_fall)
                    begin
                        next_st.bit_count = 4'h0;
                        if (st.read_dir)
                        begin
                            next_st.bus    = flsa_pkg::BUS_READ;
                            next_st.shift  = tx;
                            next_st.sda_oe = !tx[7];
                        end
                        else
                        begin
                            next_st.bus    = flsa_pkg::BUS_WRITE;
                            next_st.sda_oe = 1'b0;
                        end
                    end
                end
                flsa_pkg::BUS_READ:
                begin
                    if (scl_fall)
                    begin
                        next_st.bit_count = st.bit_count + 1'b1;
                        if (st.bit_count == 4'h7)
                        begin
                            next_st.bus    = flsa_pkg::BUS_READ_ACK;
                            next_st.sda_oe = 1'b0;
                        end
                        else
                        begin
                            next_st.shift  = {st.shift[6:0], 1'b0};
                            next_st.sda_oe = !st.shift[6];
                        end
                    end
                end
                flsa_pkg::BUS_READ_ACK:
                begin
                    if (scl_rise)
                        next_st.nack = i_sda;
                    else if (scl_fall)
                    begin
                        if (st.nack)
                            next_st.bus = flsa_pkg::BUS_SKIP;
                        else
                        begin
                            // Advance first so the next byte is served at once.
                            if (st.byte_sel == 3'h6)
                            begin
                                next_st.byte_sel = 3'h0;
                                if (st.command != flsa_pkg::CMD_READ_HOLD)
                                    next_st.rec_sel = st.rec_sel + 1'b1;
                            end
                            else
                                next_st.byte_sel = st.byte_sel + 1'b1;
                            next_st.bus       = flsa_pkg::BUS_READ;
                            next_st.bit_count = 4'h0;
                            if (st.command == flsa_pkg::CMD_UNLOCK)
                            begin
                                next_st.shift  = st.status;
                                next_st.sda_oe = !st.status[7];
                            end
                            else if (!granted)
                            begin
                                next_st.shift  = flsa_pkg::IDLE_READ_BYTE;
                                next_st.sda_oe = 1'b0;
                            end
                            else if (st.command == flsa_pkg::CMD_READ_HOLD)
                            begin
                                next_st.shift  = st.hold[next_st.byte_sel];
                                next_st.sda_oe = !next_st.shift[7];
                            end
                            else
                            begin
                                next_st.shift  = st.mem[next_st.rec_sel][next_st.byte_sel];
                                next_st.sda_oe = !next_st.shift[7];
                            end
                        end
                    end
                end
                default:
                    next_st.sda_oe = 1'b0;
            endcase
        end

        // Status is only ever one of four values, held for the next read.
        if (!i_fault_log_mode || next_st.erasing)
            next_st.status = flsa_pkg::STATUS_SAFE;
        else
        begin
            case (next_st.lock)
                flsa_pkg::LOCK_RECORDING: next_st.status = flsa_pkg::STATUS_RECORDING;
                flsa_pkg::LOCK_PENDING:   next_st.status = flsa_pkg::STATUS_PENDING;
                default:                  next_st.status = flsa_pkg::STATUS_READABLE;
            endcase
        end
        next_st.sda_out = 1'b0;
    end

    // ========================================================================
    // Registers
    // ========================================================================
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            st          <= '0;
            st.mem      <= '1;
            st.scl_prev <= 1'b1;
            st.sda_prev <= 1'b1;
            st.status   <= flsa_pkg::STATUS_SAFE;
        end
        else
            st <= next_st;
    end

    assign o_sda_out         = st.sda_out;
    assign o_sda_oe          = st.sda_oe;
    assign o_reconfig_accept = st.reconfig_accept;
    assign o_reconfig_reject = st.reconfig_reject;
    assign o_next_record     = st.next_record;
    assign o_log_full        = st.full;
    assign o_access_status   = st.status;
    assign o_program_mode    = st.program_mode;

endmodule

/* testbench/flsa_checker.sv */
/* Port checker for the fault record access block.
   Assumes it is bound to the block with every input named after a block port. */
`timescale 1ns/1ps
module flsa_checker
(
    input wire logic       i_clock,
    input wire logic       i_rst_n,
    input wire logic       i_scl,
    input wire logic       i_fault_log_mode,
    input wire logic       i_fault_event,
    input wire logic       i_reconfig_req,
    input wire logic       o_sda_oe,
    input wire logic       o_reconfig_accept,
    input wire logic       o_reconfig_reject,
    input wire logic [3:0] o_next_record,
    input wire logic [7:0] o_access_status,
    input wire logic       o_program_mode
);
    // ========================================================================
    // Properties
    // ========================================================================
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    property p_code; o_access_status inside {8'h00, 8'h30, 8'hC0, 8'hF0}; endproperty
    a_code: assert property (p_code) else $error("status value undefined");
    property p_answer; i_reconfig_req |=> ##[0:1] (o_reconfig_accept ^ o_reconfig_reject); endproperty
    a_answer: assert property (p_answer) else $error("reconfig unanswered");
    property p_quiet; !i_reconfig_req [*3] |-> !(o_reconfig_accept || o_reconfig_reject); endproperty
    a_quiet: assert property (p_quiet) else $error("reconfig answer uncaused");
    property p_ptr; $changed(o_next_record) && o_next_record != 4'h0 |-> o_next_record ==
        $past(o_next_record) + 4'h1 && ($past(i_fault_event) || $past(i_fault_event, 2)); endproperty
    a_ptr: assert property (p_ptr) else $error("pointer step wrong");
    property p_erase; $past(o_access_status) == 8'hF0 && o_access_status == 8'h00 && i_fault_log_mode
        |-> (o_program_mode && o_access_status == 8'h00)[*8]; endproperty
    a_erase: assert property (p_erase) else $error("erase without programming mode");
    property p_pend; o_access_status == 8'hC0 && $past(o_access_status) != 8'hC0
        |-> $past(o_access_status) == 8'h30; endproperty
    a_pend: assert property (p_pend) else $error("pending not from recording");
    property p_oe; $changed(o_sda_oe) |-> !$past(i_scl); endproperty
    a_oe: assert property (p_oe) else $error("data line moved with clock high");
    property p_mode; !i_fault_log_mode |=> o_access_status == 8'h00; endproperty
    a_mode: assert property (p_mode) else $error("status live outside fault-log mode");
endmodule

/* testbench/flsa_host_model.sv */
/* Two-wire bus controller model.
   Assumes the bench ANDs its data line with the device pull-down. */
`timescale 1ns/1ps
module flsa_host_model
(
    input  wire logic i_clock,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda
);
    // ========================================================================
    // Bus levels
    // ========================================================================
    // Data moves with the clock high only in start and stop, so no false start or stop appears.
    initial {o_scl, o_sda} = 2'b11;
    task automatic lv(input logic c, input logic d);
        o_scl = c;
        o_sda = d;
        repeat (4) @(negedge i_clock);
    endtask
    task automatic bt(input logic b, output logic r);
        lv(1'b0, o_sda);
        lv(1'b0, b);
        lv(1'b1, b);
        r = i_sda;
    endtask
    task automatic start();
        logic r;
        bt(1'b1, r);
        lv(1'b1, 1'b0);
    endtask
    task automatic stop();
        logic r;
        bt(1'b0, r);
        lv(1'b1, 1'b1);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bt(d[i], r);
        bt(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
        bt(last, r);
    endtask
endmodule

/* testbench/tb.sv */
/* Self-checking bench for the fault record access block.
   Assumes the checker and host model are compiled first. */
`timescale 1ns/1ps
module tb;
    logic        i_clock = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        mode    = 1'b1;
    logic        ev      = 1'b0;
    logic        rq      = 1'b0;
    logic [55:0] rec     = 56'h665544332211A5;
    logic        scl, sda_h, oe, pm, acc, rej, ak, full;
    logic [7:0]  st;
    logic [7:0]  rd [0:7];
    logic [3:0]  ptr;
    logic [1:0]  seen;
    int          fails = 0;
    int          n_compared = 0;
    wire logic   sda = sda_h & ~oe;
    always #4 i_clock = ~i_clock;
    flsa_host_model H (.i_clock(i_clock), .i_sda(sda), .o_scl(scl), .o_sda(sda_h));
    flsa_fault_log_access DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda),
        .o_sda_out(), .o_sda_oe(oe), .i_fault_log_mode(mode), .i_fault_event(ev),
        .i_fault_record(rec), .i_reconfig_req(rq), .o_reconfig_accept(acc),
        .o_reconfig_reject(rej), .o_next_record(ptr), .o_log_full(full), .o_access_status(st),
        .o_program_mode(pm));
    // ========================================================================
    // Tasks
    // ========================================================================
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic xf(input logic [7:0] c, input logic [15:0] k, input int nk, input int nr);
        H.start();
        H.wbyte({flsa_pkg::TARGET_ADDRESS, 1'b0}, ak);
        chk("address ack", ak, 1'b1);
        H.wbyte(c, ak);
        for (int i = nk; i > 0; i--) H.wbyte(k[8*i-1 -: 8], ak);
        if (nr > 0)
        begin
            H.start();
            H.wbyte({flsa_pkg::TARGET_ADDRESS, 1'b1}, ak);
            for (int i = 0; i < nr; i++) H.rbyte(i == nr - 1, rd[i]);
        end
        H.stop();
    endtask
    task automatic pulse(input logic r);
        ev = !r;
        rq = r;
        @(negedge i_clock);
        ev = 1'b0;
        rq = 1'b0;
        seen = {acc, rej};
        @(negedge i_clock);
        seen = seen | {acc, rej};
    endtask
    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ========================================================================
    // Sequence
    // ========================================================================
    initial
    begin
        repeat (4) @(negedge i_clock);
        i_rst_n = 1'b1;
        repeat (2) @(negedge i_clock);
        chk("status", st, flsa_pkg::STATUS_RECORDING);
        pulse(1'b0);
        chk("pointer", ptr, 8'h01);
        chk("not full", full, 1'b0);
        pulse(1'b1);
        chk("busy reconfig", seen, 2'h1);
        xf(flsa_pkg::CMD_READ_ALL, 16'h0, 0, 1);
        chk("locked read", rd[0], flsa_pkg::IDLE_READ_BYTE);
        xf(flsa_pkg::CMD_UNLOCK, flsa_pkg::KEY_UNLOCK, 1, 1);
        chk("pending", rd[0], flsa_pkg::STATUS_PENDING);
        repeat (flsa_pkg::PROGRAM_CYCLES) @(negedge i_clock);
        xf(flsa_pkg::CMD_UNLOCK, flsa_pkg::KEY_UNLOCK, 1, 1);
        chk("granted", rd[0], flsa_pkg::STATUS_READABLE);
        pulse(1'b1);
        chk("idle reconfig", seen, 2'h2);
        xf(flsa_pkg::CMD_READ_HOLD, 16'h0, 0, 7);
        for (int i = 0; i < 7; i++) chk("hold", rd[i], rec[8*i +: 8]);
        xf(flsa_pkg::CMD_READ_RECORD, 16'h0, 1, 8);
        for (int i = 0; i < 7; i++) chk("record", rd[i], rec[8*i +: 8]);
        chk("next record", rd[7], flsa_pkg::ERASED_BYTE);
        xf(flsa_pkg::CMD_ERASE, 16'h0, 0, 0);
        xf(flsa_pkg::CMD_READ_ALL, 16'h0, 0, 1);
        chk("kept", rd[0], rec[7:0]);
        xf(flsa_pkg::CMD_PROG_ENTER, {flsa_pkg::KEY_PROG_HI, flsa_pkg::KEY_PROG_LO}, 2, 0);
        chk("prog", pm, 1'b1);
        xf(flsa_pkg::CMD_ERASE, 16'h0, 0, 0);
        chk("erasing", st, flsa_pkg::STATUS_SAFE);
        chk("pointer", ptr, 8'h00);
        repeat (flsa_pkg::ERASE_CYCLES) @(negedge i_clock);
        xf(flsa_pkg::CMD_READ_ALL, 16'h0, 0, 1);
        chk("erased", rd[0], flsa_pkg::ERASED_BYTE);
        xf(flsa_pkg::CMD_PROG_LEAVE, 16'h0, 0, 0);
        chk("user", pm, 1'b0);
        xf(flsa_pkg::CMD_UNLOCK, 16'h0, 1, 1);
        chk("relock", rd[0], flsa_pkg::STATUS_RECORDING);
        mode = 1'b0;
        xf(flsa_pkg::CMD_UNLOCK, flsa_pkg::KEY_UNLOCK, 1, 1);
        chk("mode off", st, flsa_pkg::STATUS_SAFE);
        mode = 1'b1;
        @(negedge i_clock);
        chk("mode back", st, flsa_pkg::STATUS_RECORDING);
        finish_test();
    end
    initial
    begin
        #400000;
        fails++;
        finish_test();
    end
endmodule
bind flsa_fault_log_access flsa_checker u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_scl(i_scl),
    .i_fault_log_mode(i_fault_log_mode), .i_fault_event(i_fault_event),
    .i_reconfig_req(i_reconfig_req), .o_sda_oe(o_sda_oe), .o_reconfig_accept(o_reconfig_accept),
    .o_reconfig_reject(o_reconfig_reject), .o_next_record(o_next_record),
    .o_access_status(o_access_status), .o_program_mode(o_program_mode));
